// ### tpbf_pkg.sv
package tpbf_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned SYNC_US = 200;
  localparam int unsigned SYNC_CYC = SYNC_US * (CLK_HZ / 1_000_000);
  localparam int unsigned INHIBIT_MS = 100;
  localparam int unsigned INHIBIT_CYC = INHIBIT_MS * (CLK_HZ / 1000);
  localparam int unsigned BURST1_US = 16_667;
  localparam int unsigned BURST1_CYC = BURST1_US * (CLK_HZ / 1_000_000);
  localparam int unsigned BURST2_US = 13_333;
  localparam int unsigned BURST2_CYC = BURST2_US * (CLK_HZ / 1_000_000);
  localparam int unsigned DLY1_US = 6000;
  localparam int unsigned DLY1_CYC = DLY1_US * (CLK_HZ / 1_000_000);
  localparam int unsigned DLY2_US = 4500;
  localparam int unsigned DLY2_CYC = DLY2_US * (CLK_HZ / 1_000_000);
  localparam int unsigned TRI_STEP_DEF = 78;
  localparam int unsigned PULSE_PER_DEF = 500;
  localparam int unsigned PULSE_WID_DEF = 100;
  localparam int unsigned CNT_W = 24;
  localparam int unsigned LVL_W = 8;
  localparam logic [LVL_W-1:0] LVL_MAX = 8'hff;
endpackage

// ### tpbf_timer.sv
`timescale 1ns/10ps
`default_nettype none
module tpbf_timer (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Control
  input wire logic start_in,
  input wire logic [tpbf_pkg::CNT_W-1:0] len_in,
  // Status
  output logic busy_out,
  output logic done_out
);
  logic [tpbf_pkg::CNT_W-1:0] cnt_ff;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_ff <= '0;
      busy_out <= 1'b0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (start_in && !busy_out) begin
        cnt_ff <= len_in;
        busy_out <= 1'b1;
      end else if (busy_out) begin
        if (cnt_ff <= 24'h000001) begin
          busy_out <= 1'b0;
          done_out <= 1'b1;
        end
        cnt_ff <= cnt_ff - 24'h000001;
      end
    end
  end
endmodule
`default_nettype wire

// ### tpbf_trigger.sv
`timescale 1ns/10ps
`default_nettype none
module tpbf_trigger (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic arst_n_in,
  // Mains sync, one per phase pair, synchronous level
  input wire logic sync1_in,
  input wire logic sync2_in,
  // Configuration
  input wire logic xfmr_mode_in,
  input wire logic [tpbf_pkg::LVL_W-1:0] level_in,
  input wire logic [15:0] tri_step_in,
  input wire logic [23:0] dly1_in,
  input wire logic [23:0] dly2_in,
  input wire logic [15:0] pulse_per_in,
  input wire logic [15:0] pulse_wid_in,
  // Triac gates and status
  output logic first_phase_triac_out,
  output logic second_phase_triac_out,
  output logic third_phase_triac_out,
  output logic demand_out,
  output logic inhibit_out,
  output logic burst1_out,
  output logic burst2_out
);
  ////////////////////////////////////////////////////////////////
  logic rs1_ff, rst_n;
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rs1_ff <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rs1_ff <= 1'b1;
      rst_n <= rs1_ff;
    end
  end

  // Power-on inhibit
  logic [23:0] inh_cnt_ff;
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      inh_cnt_ff <= '0;
      inhibit_out <= 1'b1;
    end else if (inh_cnt_ff < 24'(tpbf_pkg::INHIBIT_CYC - 1)) begin
      inh_cnt_ff <= inh_cnt_ff + 24'h000001;
    end else begin
      inhibit_out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Triangle: count up then down; step sets repetition period
  logic [23:0] tri_ff;
  logic up_ff;
  localparam logic [23:0] TRI_TOP = 24'hff0000;
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      tri_ff <= '0;
      up_ff <= 1'b1;
    end else if (up_ff) begin
      if (tri_ff >= TRI_TOP - {8'h00, tri_step_in}) begin
        up_ff <= 1'b0;
      end else begin
        tri_ff <= tri_ff + {8'h00, tri_step_in};
      end
    end else begin
      if (tri_ff <= {8'h00, tri_step_in}) begin
        up_ff <= 1'b1;
      end else begin
        tri_ff <= tri_ff - {8'h00, tri_step_in};
      end
    end
  end

  // Level compared at top byte; full level means high whenever not inhibited
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      demand_out <= 1'b0;
    end else begin
      demand_out <= !inhibit_out && ((level_in == tpbf_pkg::LVL_MAX) ||
                    (tri_ff[23:16] < level_in));
    end
  end

  ////////////////////////////////////////////////////////////////
  // Sync rising edges
  logic s1_d_ff, s2_d_ff;
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      s1_d_ff <= 1'b0;
      s2_d_ff <= 1'b0;
    end else begin
      s1_d_ff <= sync1_in;
      s2_d_ff <= sync2_in;
    end
  end
  logic s1_rise, s2_rise;
  assign s1_rise = sync1_in && !s1_d_ff;
  assign s2_rise = sync2_in && !s2_d_ff;

  // One-shots: delay in transformer mode, else one cycle
  logic os1_busy, os1_done, os2_busy, os2_done;
  logic [23:0] len1, len2;
  assign len1 = xfmr_mode_in ? dly1_in : 24'h000001;
  assign len2 = xfmr_mode_in ? dly2_in : 24'h000001;
  tpbf_timer u_os1 (
    .clk_in(mclk_in),
    .rst_n_in(rst_n),
    .start_in(s1_rise && demand_out && !inhibit_out),
    .len_in(len1),
    .busy_out(os1_busy),
    .done_out(os1_done)
  );
  tpbf_timer u_os2 (
    .clk_in(mclk_in),
    .rst_n_in(rst_n),
    .start_in(s2_rise && burst1_out),
    .len_in(len2),
    .busy_out(os2_busy),
    .done_out(os2_done)
  );

  ////////////////////////////////////////////////////////////////
  // Burst enables: set by one-shot end, cleared by own sync or length
  logic [23:0] b1_cnt_ff, b2_cnt_ff;
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      burst1_out <= 1'b0;
      b1_cnt_ff <= '0;
    end else if (os1_done) begin
      burst1_out <= 1'b1;
      b1_cnt_ff <= 24'(tpbf_pkg::BURST1_CYC);
    end else if (burst1_out) begin
      b1_cnt_ff <= b1_cnt_ff - 24'h000001;
      // Sync clears only while its one-shot is idle, on the edge that restarts it; demand drop cannot cut it
      if ((s1_rise && !os1_busy) || b1_cnt_ff <= 24'h000001) begin
        burst1_out <= 1'b0;
      end
    end
  end
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      burst2_out <= 1'b0;
      b2_cnt_ff <= '0;
    end else if (os2_done) begin
      burst2_out <= 1'b1;
      b2_cnt_ff <= 24'(tpbf_pkg::BURST2_CYC);
    end else if (burst2_out) begin
      b2_cnt_ff <= b2_cnt_ff - 24'h000001;
      if ((s2_rise && !os2_busy) || b2_cnt_ff <= 24'h000001) begin
        burst2_out <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Pulse train
  logic [15:0] pcnt_ff;
  logic ptrain;
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      pcnt_ff <= '0;
    end else if (pcnt_ff + 16'h0001 >= pulse_per_in) begin
      pcnt_ff <= '0;
    end else begin
      pcnt_ff <= pcnt_ff + 16'h0001;
    end
  end
  assign ptrain = pcnt_ff < pulse_wid_in;

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      first_phase_triac_out <= 1'b0;
      second_phase_triac_out <= 1'b0;
      third_phase_triac_out <= 1'b0;
    end else begin
      first_phase_triac_out <= burst1_out && ptrain && !inhibit_out;
      second_phase_triac_out <= burst2_out && ptrain && !inhibit_out;
      // In transformer mode only, steady gate drive keeps the third triac conducting through every zero crossing
      third_phase_triac_out <= xfmr_mode_in && !inhibit_out;
    end
  end

  ////////////////////////////////////////////////////////////////
  chk_gate_needs_burst: assert property (@(posedge mclk_in) disable iff (!rst_n)
    first_phase_triac_out |-> $past(burst1_out))
    else $error("first gate pulse without burst");
  chk_gate2_needs_burst: assert property (@(posedge mclk_in) disable iff (!rst_n)
    second_phase_triac_out |-> $past(burst2_out))
    else $error("second gate pulse without burst");
  chk_inhibit_blocks: assert property (@(posedge mclk_in) disable iff (!rst_n)
    inhibit_out |-> !demand_out)
    else $error("demand during inhibit");
  chk_demand_low_cmp: assert property (@(posedge mclk_in) disable iff (!rst_n)
    (level_in != tpbf_pkg::LVL_MAX && tri_ff[23:16] >= level_in) |=> !demand_out)
    else $error("demand high above level");
  chk_burst1_set: assert property (@(posedge mclk_in) disable iff (!rst_n)
    os1_done |=> burst1_out)
    else $error("burst1 not set by one-shot");
  chk_burst1_clear: assert property (@(posedge mclk_in) disable iff (!rst_n)
    (burst1_out && s1_rise && !os1_busy && !os1_done) |=> !burst1_out)
    else $error("burst1 not cleared by sync");
  chk_os1_blocked: assert property (@(posedge mclk_in) disable iff (!rst_n)
    (!demand_out && !os1_busy) |=> !os1_busy)
    else $error("one-shot fired without demand");
  chk_third_on: assert property (@(posedge mclk_in) disable iff (!rst_n)
    (xfmr_mode_in && !inhibit_out) |=> third_phase_triac_out)
    else $error("third triac not triggered");
endmodule
`default_nettype wire

// ### tpbf_sync_model.sv
`timescale 1ns/10ps
`default_nettype none
module tpbf_sync_model #(
  parameter int PER = 200000,
  parameter int OFF = 33333
) (
  // Clock and control
  input wire logic mclk_in,
  input wire logic en_in,
  // Sync levels
  output logic sync1_out,
  output logic sync2_out
);
  int ph_ff;
  // Phase restarts on enable so the first sync lands right away
  always_ff @(posedge mclk_in) begin
    ph_ff <= (!en_in || ph_ff == PER - 1) ? 0 : ph_ff + 1;
  end
  always_ff @(posedge mclk_in) begin
    sync1_out <= en_in && ph_ff < tpbf_pkg::SYNC_CYC;
    sync2_out <= en_in && ph_ff >= OFF && ph_ff < OFF + tpbf_pkg::SYNC_CYC;
  end
endmodule
`default_nettype wire

// ### testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam int PER = 200000;
  logic mclk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic xf = 1'b0;
  logic en = 1'b0;
  logic [7:0] lvl = 8'hff;
  logic [15:0] step = 16'hffff;
  logic [23:0] d1 = 24'h0003e8;
  logic [23:0] d2 = 24'h0003e8;
  logic [15:0] per = 16'h00c8;
  logic s1, s2, tr1, tr2, tr3, dem, inh, b1, b2;
  logic [1:0] sp, bp, tp;
  int error_cnt = 0;
  int n_compared = 0;
  int seed = 47;
  int qd[$];
  int cyc[2], w[2], np[2], stray;
  tpbf_sync_model #(.PER(PER), .OFF(33333)) u_sync (.mclk_in(mclk_in), .en_in(en),
    .sync1_out(s1), .sync2_out(s2));
  tpbf_trigger u_dut (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .sync1_in(s1),
    .sync2_in(s2), .xfmr_mode_in(xf), .level_in(lvl), .tri_step_in(step), .dly1_in(d1),
    .dly2_in(d2), .pulse_per_in(per), .pulse_wid_in(16'h0032),
    .first_phase_triac_out(tr1), .second_phase_triac_out(tr2),
    .third_phase_triac_out(tr3), .demand_out(dem), .inhibit_out(inh),
    .burst1_out(b1), .burst2_out(b2));
  initial forever #50 mclk_in = ~mclk_in;
  initial begin
    repeat (2500000) @(posedge mclk_in);
    error_cnt++;
    wrap_up();
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input int tol,
    input string what);
    n_compared++;
    if ((^seen) === 1'bx || seen + tol < exp || seen > exp + tol) begin
      error_cnt++;
      $display("wrong value %s expected %0d seen %0d", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Bursts with no note queued come back as -1 and fail
  always @(posedge mclk_in) begin
    for (int i = 0; i < 2; i++) begin
      cyc[i] = ({s2, s1} >> i & 1 && !sp[i]) ? 0 : cyc[i] + 1;
      if ({b2, b1} >> i & 1 && !bp[i]) begin
        check(i * 1000000 + cyc[i], qd.size() ? qd.pop_front() : -1, 3, "start");
        w[i] = 0;
        np[i] = 0;
      end
      if ({b2, b1} >> i & 1) w[i]++;
      if ({b2, b1} >> i & 1 && {tr2, tr1} >> i & 1 && !tp[i]) np[i]++;
      if (!({b2, b1} >> i & 1) && bp[i]) begin
        check(w[i], i ? tpbf_pkg::BURST2_CYC : tpbf_pkg::BURST1_CYC, 2, "length");
        check(np[i], w[i] / per, 1, "pulses");
        check(tr3, xf, 0, "third gate");
      end
      if ({tr2, tr1} >> i & 1 && !({b2, b1} >> i & 1) && !bp[i]) stray++;
    end
    sp = {s2, s1};
    bp = {b2, b1};
    tp = {tr2, tr1};
  end
  task automatic run(input int n, input logic x, input logic [7:0] lv, input string nm);
    @(negedge mclk_in);
    xf = x;
    lvl = lv;
    d1 = 24'd1000 + 24'($random(seed) & 32'h1fff);
    d2 = 24'd1000 + 24'($random(seed) & 32'h1fff);
    per = 16'd200 + 16'($random(seed) & 32'hff);
    repeat (4) @(negedge mclk_in);
    for (int k = 0; k < n && lv != 0; k++) begin
      qd.push_back(x ? d1 + 2 : 3);
      qd.push_back(1000000 + (x ? d2 + 2 : 3));
    end
    en = 1'b1;
    repeat (n * PER) @(negedge mclk_in);
    en = 1'b0;
    repeat (100) @(negedge mclk_in);
    check(tr3, x, 0, "third idle");
    $display("test %s done", nm);
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    int n;
    int dh;
    n = 0;
    dh = 0;
    repeat (6) @(negedge mclk_in);
    check(inh, 1, 0, "inhibit reset");
    arst_n_in = 1'b1;
    en = 1'b1;
    while (inh !== 1'b0 && n < 1100000) begin
      @(negedge mclk_in);
      n++;
      if (dem !== 1'b0) dh++;
    end
    en = 1'b0;
    check(n, tpbf_pkg::INHIBIT_CYC + 2, 4, "inhibit span");
    check(dh, 0, 0, "inhibit demand");
    $display("test inhibit done");
    for (int k = 0; k < 5; k++) begin
      lvl = (k == 4) ? 8'hff : 8'(k * 64);
      repeat (600) @(negedge mclk_in);
      dh = 0;
      repeat (51000) begin
        @(negedge mclk_in);
        if (dem === 1'b1) dh++;
      end
      check(dh, lvl * 51000 / 256, 900, "duty");
    end
    $display("test duty done");
    // Slow triangle keeps full demand away from the top during bursts
    step = 16'h0001;
    run(2, 1'b0, 8'hff, "normal");
    run(2, 1'b1, 8'hff, "transformer");
    run(1, 1'b0, 8'h00, "no demand");
    check(stray, 0, 0, "stray pulses");
    check(qd.size(), 0, 0, "missing bursts");
    wrap_up();
  end
endmodule
`default_nettype wire
